/* drive_frequency_reference_select.sv */
`timescale 1ns/10ps
`default_nettype none
module drive_frequency_reference_select #(
	parameter int unsigned HOLD_CYC = drive_ref_pkg::HOLD_MIN_CYC,
	parameter int unsigned UPDN_CYC = drive_ref_pkg::UPDN_TICK_CYC
) (
	input  wire logic                    clk,
	input  wire logic                    srst,
	input  wire logic [4:0]              addr,
	input  wire logic [31:0]             wdata,
	input  wire logic                    wr,
	input  wire logic                    rd,
	output logic [31:0]                  rdata,
	input  wire logic                    settings_init,
	input  wire logic                    forward_run_input,
	input  wire logic                    reverse_run_input,
	input  wire logic [5:0]              spare_digital_inputs,
	input  wire drive_ref_pkg::run_cmd_s keypad_run,
	input  wire drive_ref_pkg::run_cmd_s comm_run,
	input  wire drive_ref_pkg::run_cmd_s plc_run,
	input  wire logic [15:0]             keypad_ref,
	input  wire logic                    comm_ref_valid,
	input  wire logic [15:0]             comm_ref_data,
	input  wire logic [11:0]             first_analog_input,
	input  wire logic [11:0]             second_analog_input,
	input  wire logic [15:0]             pulse_train_input,
	input  wire logic                    motor_sel,
	input  wire logic                    power_off,
	input  wire logic                    sleeping,
	input  wire logic [15:0]             pid_out,
	output drive_ref_pkg::run_cmd_s      run_cmd,
	output logic [15:0]                  freq_ref,
	output logic [15:0]                  pid_limited,
	output drive_ref_pkg::cfg_err_s      errors,
	output logic [2:0]                   analog_type,
	output logic [1:0]                   language
);
	function automatic logic term_match(input logic [47:0] fn, input logic [5:0] act,
		input logic [7:0] code);
		logic hit;
		hit = 1'b0;
		for (int k = 0; k < 6; k++) begin
			hit = hit | (act[k] && fn[8*k +: 8] == code);
		end
		return hit;
	endfunction

	function automatic logic [15:0] ain_ref(input logic [11:0] code, input logic bip,
		input logic cur, input logic [15:0] fmax);
		logic [11:0] u;
		logic [13:0] m;
		logic [27:0] p;
		u = code;
		m = {2'b00, code - drive_ref_pkg::CUR_OFS} * 14'h0005;
		if (bip) begin
			u = code[11] ? 12'h000 : {code[10:0], 1'b0};
		end else if (cur) begin
			u = (code < drive_ref_pkg::CUR_OFS) ? 12'h000 : m[13:2];
		end
		p = {16'h0000, u} * {12'h000, fmax};
		return p[27:12];
	endfunction

	function automatic logic [15:0] sat_add(input logic [15:0] a, input logic [15:0] b);
		logic [16:0] s;
		s = {1'b0, a} + {1'b0, b};
		return (s > {1'b0, drive_ref_pkg::FREQ_MAX}) ? drive_ref_pkg::FREQ_MAX : s[15:0];
	endfunction

	function automatic logic [15:0] pct_of(input logic [15:0] fmax, input logic [10:0] pct);
		logic [26:0] p;
		p = {11'h000, fmax} * {16'h0000, pct};
		p = p / drive_ref_pkg::PCT_DIV;
		return p[15:0];
	endfunction

	function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo,
		input logic [15:0] hi);
		if (v > hi) begin
			return hi;
		end else if (v < lo) begin
			return lo;
		end
		return v;
	endfunction

	logic [1:0]  run_src_r;
	logic [2:0]  main_r;
	logic [2:0]  alt_r;
	logic        combine_r;
	logic [2:0]  ain_type_r;
	logic [7:0]  ain2_fn_r;
	logic [7:0]  pulse_fn_r;
	logic        retain_r;
	logic        sleep_lim_r;
	logic [10:0] upper_r;
	logic [10:0] lower_r;
	logic [1:0]  lang_r;
	logic [15:0] preset0_r;
	logic [15:0] fmax1_r;
	logic [15:0] fmax2_r;
	logic [47:0] term_fn_r;
	logic [15:0] comm_ref_r;
	logic [7:0]  pin_m_r;
	logic [7:0]  pin_s_r;
	logic [21:0] hold_cnt_r [3];
	logic [2:0]  hold_pin;
	logic [2:0]  hold_ok;
	drive_ref_pkg::run_cmd_s hold_run_r;
	drive_ref_pkg::run_cmd_s term_cmd;
	logic [15:0] updn_r;
	logic [15:0] tick_r;
	logic [15:0] fmax;
	logic [15:0] up_hz;
	logic [15:0] lo_hz;
	logic [15:0] ai1_v;
	logic [15:0] ai2_v;
	logic [15:0] src_v [8];
	logic [15:0] alt_v;
	logic [15:0] sum_v;
	logic        hold_mode;
	logic        has_up;
	logic        has_dn;
	logic        comm_sel;
	logic        lim_err;
	logic [31:0] rd_mux;

	// Parameter store; settings_init restores defaults except the language
	always_ff @(posedge clk) begin
		if (srst || settings_init) begin
			run_src_r   <= drive_ref_pkg::RUN_KEYPAD;
			main_r      <= drive_ref_pkg::SRC_KEYPAD;
			alt_r       <= drive_ref_pkg::SRC_KEYPAD;
			combine_r   <= 1'b0;
			ain_type_r  <= drive_ref_pkg::RST_AIN_TYPE;
			ain2_fn_r   <= drive_ref_pkg::AIN2_AUX;
			pulse_fn_r  <= drive_ref_pkg::PULSE_REF;
			retain_r    <= 1'b0;
			sleep_lim_r <= 1'b0;
			upper_r     <= drive_ref_pkg::RST_UPPER;
			lower_r     <= drive_ref_pkg::RST_LOWER;
			preset0_r   <= 16'h0000;
			fmax1_r     <= drive_ref_pkg::RST_FMAX;
			fmax2_r     <= drive_ref_pkg::RST_FMAX;
			term_fn_r   <= drive_ref_pkg::RST_TERM;
		end else if (wr) begin
			case (addr)
				drive_ref_pkg::REG_RUN_SRC:   run_src_r <= wdata[1:0];
				drive_ref_pkg::REG_MAIN:      main_r <= wdata[2:0];
				drive_ref_pkg::REG_ALT:       alt_r <= wdata[2:0];
				drive_ref_pkg::REG_COMBINE:   combine_r <= wdata[0];
				drive_ref_pkg::REG_AIN_TYPE:  ain_type_r <= wdata[2:0];
				drive_ref_pkg::REG_AIN2_FN:   ain2_fn_r <= wdata[7:0];
				drive_ref_pkg::REG_PULSE_FN:  pulse_fn_r <= wdata[7:0];
				drive_ref_pkg::REG_RETAIN:    retain_r <= wdata[0];
				drive_ref_pkg::REG_SLEEP_LIM: sleep_lim_r <= wdata[0];
				drive_ref_pkg::REG_UPPER: begin
					if (wdata[10:0] >= drive_ref_pkg::PCT_MIN_UP &&
						wdata[10:0] <= drive_ref_pkg::PCT_MAX) begin
						upper_r <= wdata[10:0];
					end
				end
				drive_ref_pkg::REG_LOWER: begin
					if (wdata[10:0] <= drive_ref_pkg::PCT_MAX) begin
						lower_r <= wdata[10:0];
					end
				end
				drive_ref_pkg::REG_PRESET0:   preset0_r <= wdata[15:0];
				drive_ref_pkg::REG_FMAX1:     fmax1_r <= wdata[15:0];
				drive_ref_pkg::REG_FMAX2:     fmax2_r <= wdata[15:0];
				drive_ref_pkg::REG_TERM_LO:   term_fn_r[31:0] <= wdata;
				drive_ref_pkg::REG_TERM_HI:   term_fn_r[47:32] <= wdata[15:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			lang_r <= 2'h0;
		end else if (wr && addr == drive_ref_pkg::REG_LANG) begin
			lang_r <= wdata[1:0];
		end
	end

	// Terminal pins cross in from outside
	always_ff @(posedge clk) begin
		if (srst) begin
			pin_m_r <= 8'h00;
			pin_s_r <= 8'h00;
		end else begin
			pin_m_r <= {spare_digital_inputs, reverse_run_input, forward_run_input};
			pin_s_r <= pin_m_r;
		end
	end

	assign hold_mode = term_match(term_fn_r, 6'h3f, drive_ref_pkg::FN_HOLD2W);
	assign hold_pin  = {pin_s_r[4], pin_s_r[1], pin_s_r[0]};

	// A press only counts once it has stayed closed for the hold time
	for (genvar i = 0; i < 3; i++) begin : g_hold
		always_ff @(posedge clk) begin
			if (srst || !hold_pin[i]) begin
				hold_cnt_r[i] <= 22'h0;
			end else if (!hold_ok[i]) begin
				hold_cnt_r[i] <= hold_cnt_r[i] + 22'h1;
			end
		end
		assign hold_ok[i] = hold_cnt_r[i] >= 22'(HOLD_CYC);
	end

	// Hold run latch: the fifth input opening stops the drive
	always_ff @(posedge clk) begin
		if (srst || !hold_mode || !pin_s_r[4]) begin
			hold_run_r <= '{fwd: 1'b0, rev: 1'b0};
		end else if (hold_ok[0] && hold_ok[2]) begin
			hold_run_r <= '{fwd: 1'b1, rev: 1'b0};
		end else if (hold_ok[1] && hold_ok[2]) begin
			hold_run_r <= '{fwd: 1'b0, rev: 1'b1};
		end
	end

	always_comb begin
		term_cmd.fwd = pin_s_r[0] && !pin_s_r[1];
		term_cmd.rev = pin_s_r[1] && !pin_s_r[0];
		if (hold_mode) begin
			term_cmd = hold_run_r;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			run_cmd <= '{fwd: 1'b0, rev: 1'b0};
		end else begin
			case (run_src_r)
				drive_ref_pkg::RUN_KEYPAD: run_cmd <= keypad_run;
				drive_ref_pkg::RUN_TERM:   run_cmd <= term_cmd;
				drive_ref_pkg::RUN_COMM:   run_cmd <= comm_run;
				drive_ref_pkg::RUN_PLC:    run_cmd <= plc_run;
				default:                   run_cmd <= '{fwd: 1'b0, rev: 1'b0};
			endcase
		end
	end

	assign has_up = term_match(term_fn_r, 6'h3f, drive_ref_pkg::FN_UP);
	assign has_dn = term_match(term_fn_r, 6'h3f, drive_ref_pkg::FN_DOWN);

	// Up/down reference steps 0.01 Hz per tick
	always_ff @(posedge clk) begin
		if (srst) begin
			tick_r <= 16'h0000;
			updn_r <= 16'h0000;
		end else begin
			tick_r <= (tick_r >= 16'(UPDN_CYC - 1)) ? 16'h0000 : tick_r + 16'h0001;
			if (tick_r == 16'h0000 && has_up && has_dn) begin
				if (term_match(term_fn_r, pin_s_r[7:2], drive_ref_pkg::FN_UP)) begin
					updn_r <= (updn_r < fmax) ? updn_r + 16'h0001 : fmax;
				end else if (term_match(term_fn_r, pin_s_r[7:2], drive_ref_pkg::FN_DOWN) &&
					updn_r != 16'h0000) begin
					updn_r <= updn_r - 16'h0001;
				end
			end
		end
	end

	assign comm_sel = main_r == drive_ref_pkg::SRC_COMM || alt_r == drive_ref_pkg::SRC_COMM;

	// A new serial value wins over a power-off clear in the same cycle
	always_ff @(posedge clk) begin
		if (srst) begin
			comm_ref_r <= 16'h0000;
		end else if (comm_ref_valid) begin
			comm_ref_r <= clamp(comm_ref_data, 16'h0000, drive_ref_pkg::FREQ_MAX);
		end else if (power_off && !(retain_r && comm_sel)) begin
			comm_ref_r <= 16'h0000;
		end
	end

	assign fmax  = motor_sel ? fmax2_r : fmax1_r;
	assign up_hz = pct_of(fmax, upper_r);
	assign lo_hz = pct_of(fmax, lower_r);
	assign lim_err = upper_r < lower_r;
	assign ai1_v = ain_ref(first_analog_input, ain_type_r[1], 1'b0, fmax);
	assign ai2_v = ain_ref(second_analog_input, 1'b0, ain_type_r[0], fmax);

	always_comb begin
		for (int k = 0; k < 8; k++) begin
			src_v[k] = 16'h0000;
		end
		src_v[drive_ref_pkg::SRC_KEYPAD] = keypad_ref;
		src_v[drive_ref_pkg::SRC_ANALOG] = ai1_v;
		if (ain2_fn_r == drive_ref_pkg::AIN2_ADD) begin
			src_v[drive_ref_pkg::SRC_ANALOG] = sat_add(ai1_v, ai2_v);
		end
		src_v[drive_ref_pkg::SRC_UPDN] = (has_up && has_dn) ? updn_r : 16'h0000;
		src_v[drive_ref_pkg::SRC_COMM] = comm_ref_r;
		if (pulse_fn_r == drive_ref_pkg::PULSE_REF) begin
			src_v[drive_ref_pkg::SRC_PULSE] = pulse_train_input;
		end
		if (ain2_fn_r == drive_ref_pkg::AIN2_AUX) begin
			src_v[drive_ref_pkg::SRC_AUX] = ai2_v;
		end
	end

	assign alt_v = (alt_r == drive_ref_pkg::SRC_KEYPAD) ? preset0_r : src_v[alt_r];
	assign sum_v = combine_r ? sat_add(src_v[main_r], alt_v) : src_v[main_r];

	always_ff @(posedge clk) begin
		if (srst) begin
			freq_ref <= 16'h0000;
		end else begin
			freq_ref <= clamp(sum_v, lo_hz, up_hz);
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			pid_limited <= 16'h0000;
		end else if (sleeping) begin
			pid_limited <= sleep_lim_r ? 16'h0000 : lo_hz;
		end else begin
			pid_limited <= clamp(pid_out, lo_hz, up_hz);
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			errors <= '{default: 1'b0};
		end else begin
			errors.source_conflict_error <= combine_r && main_r == alt_r;
			errors.start_mode_conflict_error <= hold_mode &&
				term_match(term_fn_r, 6'h3f, drive_ref_pkg::FN_3WIRE);
			errors.limit_range_error <= lim_err;
		end
	end

	assign analog_type = ain_type_r;
	assign language    = lang_r;

	always_comb begin
		rd_mux = 32'h0000_0000;
		case (addr)
			drive_ref_pkg::REG_RUN_SRC:   rd_mux[1:0] = run_src_r;
			drive_ref_pkg::REG_MAIN:      rd_mux[2:0] = main_r;
			drive_ref_pkg::REG_ALT:       rd_mux[2:0] = alt_r;
			drive_ref_pkg::REG_COMBINE:   rd_mux[0] = combine_r;
			drive_ref_pkg::REG_AIN_TYPE:  rd_mux[2:0] = ain_type_r;
			drive_ref_pkg::REG_AIN2_FN:   rd_mux[7:0] = ain2_fn_r;
			drive_ref_pkg::REG_PULSE_FN:  rd_mux[7:0] = pulse_fn_r;
			drive_ref_pkg::REG_RETAIN:    rd_mux[0] = retain_r;
			drive_ref_pkg::REG_SLEEP_LIM: rd_mux[0] = sleep_lim_r;
			drive_ref_pkg::REG_UPPER:     rd_mux[10:0] = upper_r;
			drive_ref_pkg::REG_LOWER:     rd_mux[10:0] = lower_r;
			drive_ref_pkg::REG_LANG:      rd_mux[1:0] = lang_r;
			drive_ref_pkg::REG_PRESET0:   rd_mux[15:0] = preset0_r;
			drive_ref_pkg::REG_FMAX1:     rd_mux[15:0] = fmax1_r;
			drive_ref_pkg::REG_FMAX2:     rd_mux[15:0] = fmax2_r;
			drive_ref_pkg::REG_TERM_LO:   rd_mux = term_fn_r[31:0];
			drive_ref_pkg::REG_TERM_HI:   rd_mux[15:0] = term_fn_r[47:32];
			drive_ref_pkg::REG_COMM_REF:  rd_mux[15:0] = comm_sel ? comm_ref_r : 16'h0000;
			drive_ref_pkg::REG_STATUS:    rd_mux[5:0] = {errors, run_cmd, hold_mode};
			drive_ref_pkg::REG_FREQ:      rd_mux[15:0] = freq_ref;
			default:                      rd_mux = 32'h0000_0000;
		endcase
	end

	// Read data is valid only in the cycle after the strobe
	always_ff @(posedge clk) begin
		if (srst || !rd) begin
			rdata <= 32'h0000_0000;
		end else begin
			rdata <= rd_mux;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	property p_start_conflict;
		hold_mode && term_match(term_fn_r, 6'h3f, drive_ref_pkg::FN_3WIRE)
			|=> errors.start_mode_conflict_error;
	endproperty
	a_start_conflict: assert property (p_start_conflict) else $error("start conflict missing");

	property p_src_conflict;
		combine_r && main_r == alt_r |=> errors.source_conflict_error;
	endproperty
	a_src_conflict: assert property (p_src_conflict) else $error("source conflict missing");

	property p_clamp;
		!lim_err |=> freq_ref <= $past(up_hz) && freq_ref >= $past(lo_hz);
	endproperty
	a_clamp: assert property (p_clamp) else $error("reference outside limits");

	property p_sleep;
		sleeping |=> pid_limited == ($past(sleep_lim_r) ? 16'h0000 : $past(lo_hz));
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep PID limit wrong");

	property p_run_comm;
		run_src_r == drive_ref_pkg::RUN_COMM |=> run_cmd == $past(comm_run);
	endproperty
	a_run_comm: assert property (p_run_comm) else $error("serial run not followed");

	property p_hold_stop;
		(hold_mode && run_src_r == drive_ref_pkg::RUN_TERM && !pin_s_r[4])[*2]
			|-> ##1 !run_cmd.fwd && !run_cmd.rev;
	endproperty
	a_hold_stop: assert property (p_hold_stop) else $error("hold run not stopped");

	property p_comm_read;
		rd && addr == drive_ref_pkg::REG_COMM_REF && comm_sel
			|=> rdata == {16'h0000, $past(comm_ref_r)};
	endproperty
	a_comm_read: assert property (p_comm_read) else $error("serial reference read wrong");

	property p_lang_keep;
		settings_init && !(wr && addr == drive_ref_pkg::REG_LANG) |=> $stable(lang_r);
	endproperty
	a_lang_keep: assert property (p_lang_keep) else $error("language lost on init");

	property p_comm_drop;
		power_off && !comm_ref_valid && !(retain_r && comm_sel) |=> comm_ref_r == 16'h0000;
	endproperty
	a_comm_drop: assert property (p_comm_drop) else $error("serial reference kept");
endmodule
`default_nettype wire

/* drive_ref_pkg.sv */
package drive_ref_pkg;
	localparam int unsigned CLK_HZ        = 40_000_000;
	localparam int unsigned HOLD_MIN_MS   = 50;
	localparam int unsigned HOLD_MIN_CYC  = CLK_HZ / 1000 * HOLD_MIN_MS;
	localparam int unsigned UPDN_TICK_US  = 1000;
	localparam int unsigned UPDN_TICK_CYC = CLK_HZ / 1_000_000 * UPDN_TICK_US;
	localparam logic [7:0]  FN_HOLD2W = 8'h35;
	localparam logic [7:0]  FN_3WIRE  = 8'h1a;
	localparam logic [7:0]  FN_UP     = 8'h06;
	localparam logic [7:0]  FN_DOWN   = 8'h07;
	localparam logic [7:0]  AIN2_AUX  = 8'h00;
	localparam logic [7:0]  AIN2_ADD  = 8'h0a;
	localparam logic [7:0]  PULSE_REF = 8'h00;
	localparam logic [15:0] FREQ_MAX  = 16'he9fc;
	localparam logic [10:0] PCT_MAX   = 11'h442;
	localparam logic [10:0] PCT_MIN_UP = 11'h001;
	localparam logic [26:0] PCT_DIV   = 27'h3e8;
	localparam logic [11:0] CUR_OFS   = 12'h333;
	localparam logic [4:0] REG_RUN_SRC   = 5'h00;
	localparam logic [4:0] REG_MAIN      = 5'h01;
	localparam logic [4:0] REG_ALT       = 5'h02;
	localparam logic [4:0] REG_COMBINE   = 5'h03;
	localparam logic [4:0] REG_AIN_TYPE  = 5'h04;
	localparam logic [4:0] REG_AIN2_FN   = 5'h05;
	localparam logic [4:0] REG_PULSE_FN  = 5'h06;
	localparam logic [4:0] REG_RETAIN    = 5'h07;
	localparam logic [4:0] REG_SLEEP_LIM = 5'h08;
	localparam logic [4:0] REG_UPPER     = 5'h09;
	localparam logic [4:0] REG_LOWER     = 5'h0a;
	localparam logic [4:0] REG_LANG      = 5'h0b;
	localparam logic [4:0] REG_PRESET0   = 5'h0c;
	localparam logic [4:0] REG_FMAX1     = 5'h0d;
	localparam logic [4:0] REG_FMAX2     = 5'h0e;
	localparam logic [4:0] REG_TERM_LO   = 5'h0f;
	localparam logic [4:0] REG_TERM_HI   = 5'h10;
	localparam logic [4:0] REG_COMM_REF  = 5'h11;
	localparam logic [4:0] REG_STATUS    = 5'h12;
	localparam logic [4:0] REG_FREQ      = 5'h13;
	localparam logic [2:0]  RST_AIN_TYPE = 3'h1;
	localparam logic [10:0] RST_UPPER    = 11'h3e8;
	localparam logic [10:0] RST_LOWER    = 11'h000;
	localparam logic [15:0] RST_FMAX     = 16'h1770;
	localparam logic [47:0] RST_TERM     = 48'h0;
	typedef enum logic [1:0] {
		RUN_KEYPAD = 2'h0, RUN_TERM = 2'h1, RUN_COMM = 2'h2, RUN_PLC = 2'h3
	} run_src_e;
	typedef enum logic [2:0] {
		SRC_KEYPAD = 3'h0, SRC_ANALOG = 3'h1, SRC_UPDN = 3'h2, SRC_COMM = 3'h3,
		SRC_PULSE = 3'h4, SRC_AUX = 3'h7
	} freq_src_e;
	typedef struct packed {
		logic fwd;
		logic rev;
	} run_cmd_s;
	typedef struct packed {
		logic source_conflict_error;
		logic start_mode_conflict_error;
		logic limit_range_error;
	} cfg_err_s;
endpackage

/* field_side_model.sv */
`timescale 1ns/10ps
`default_nettype none
module field_side_model (
	input  wire logic        clk,
	output logic             forward_run_input,
	output logic             reverse_run_input,
	output logic [5:0]       spare_digital_inputs,
	output logic             comm_ref_valid,
	output logic [15:0]      comm_ref_data
);
	initial begin
		{spare_digital_inputs, reverse_run_input, forward_run_input} = 8'h00;
		comm_ref_valid = 1'b0;
		comm_ref_data = 16'h0000;
	end

	// Contacts move just after an edge and stay until the next command
	task automatic press(input logic [7:0] pins);
		@(posedge clk);
		{spare_digital_inputs, reverse_run_input, forward_run_input} <= pins;
	endtask

	// One-cycle frame; the data lines carry junk outside it
	task automatic send_ref(input logic [15:0] ref_val);
		@(posedge clk);
		comm_ref_valid <= 1'b1;
		comm_ref_data <= ref_val;
		@(posedge clk);
		comm_ref_valid <= 1'b0;
		comm_ref_data <= ~ref_val;
	endtask
endmodule
`default_nettype wire

/* drive_frequency_reference_select_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module drive_frequency_reference_select_bench;
	logic                    clk, srst, wr, rd, settings_init, power_off, sleeping, motor_sel;
	logic [4:0]              addr;
	logic [31:0]             wdata, rdata, v;
	logic [15:0]             keypad_ref, pid_out, freq_ref, pid_limited, pulse_train_input;
	logic [15:0]             comm_ref_data;
	logic [11:0]             first_analog_input, second_analog_input;
	logic                    forward_run_input, reverse_run_input, comm_ref_valid;
	logic [5:0]              spare_digital_inputs;
	logic [2:0]              analog_type;
	logic [1:0]              language;
	drive_ref_pkg::run_cmd_s keypad_run, comm_run, plc_run, run_cmd;
	drive_ref_pkg::cfg_err_s errors;
	int                      fails = 0;
	int                      n_checks = 0;
	int                      n;

	drive_frequency_reference_select #(.HOLD_CYC(20), .UPDN_CYC(4)) i_dut (
		.clk, .srst, .addr, .wdata, .wr, .rd, .rdata, .settings_init,
		.forward_run_input, .reverse_run_input, .spare_digital_inputs,
		.keypad_run, .comm_run, .plc_run, .keypad_ref, .comm_ref_valid, .comm_ref_data,
		.first_analog_input, .second_analog_input, .pulse_train_input, .motor_sel,
		.power_off, .sleeping, .pid_out, .run_cmd, .freq_ref, .pid_limited, .errors,
		.analog_type, .language
	);
	field_side_model field (
		.clk, .forward_run_input, .reverse_run_input, .spare_digital_inputs,
		.comm_ref_valid, .comm_ref_data
	);

	task automatic finish_test;
		if (fails == 0 && n_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wreg(input logic [4:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [4:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic settle;
		repeat (4) @(posedge clk);
		#1;
	endtask
	task automatic pulse_off;
		@(posedge clk);
		power_off <= 1'b1;
		@(posedge clk);
		power_off <= 1'b0;
		settle();
	endtask

	task automatic t_regs;
		rreg(drive_ref_pkg::REG_AIN_TYPE, v);
		chk(v, 32'h1);
		rreg(5'h1f, v);
		chk(v, 32'h0);
		wreg(drive_ref_pkg::REG_UPPER, 32'h0);
		rreg(drive_ref_pkg::REG_UPPER, v);
		chk(v, 32'h3e8);
	endtask
	task automatic t_src;
		logic [2:0] s[5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h7};
		logic [15:0] e[5] = '{16'h04d2, 16'h0bb8, 16'h0000, 16'h0309, 16'h05dc};
		wreg(drive_ref_pkg::REG_AIN_TYPE, 32'h0);
		for (int i = 0; i < 5; i++) begin
			wreg(drive_ref_pkg::REG_MAIN, {29'h0, s[i]});
			settle();
			chk(freq_ref, e[i]);
		end
	endtask
	task automatic t_sum;
		wreg(drive_ref_pkg::REG_MAIN, 32'h4);
		wreg(drive_ref_pkg::REG_ALT, 32'h0);
		wreg(drive_ref_pkg::REG_PRESET0, 32'h00c8);
		wreg(drive_ref_pkg::REG_COMBINE, 32'h1);
		settle();
		chk(freq_ref, 16'h03d1);
		wreg(drive_ref_pkg::REG_ALT, 32'h4);
		settle();
		chk(errors.source_conflict_error, 1'b1);
		wreg(drive_ref_pkg::REG_COMBINE, 32'h0);
		settle();
		chk(errors.source_conflict_error, 1'b0);
		chk(freq_ref, 16'h0309);
	endtask
	task automatic t_comm;
		wreg(drive_ref_pkg::REG_MAIN, 32'h3);
		field.send_ref(16'h09c4);
		settle();
		chk(freq_ref, 16'h09c4);
		rreg(drive_ref_pkg::REG_COMM_REF, v);
		chk(v, 32'h09c4);
		pulse_off();
		rreg(drive_ref_pkg::REG_COMM_REF, v);
		chk(v, 32'h0);
		wreg(drive_ref_pkg::REG_RETAIN, 32'h1);
		field.send_ref(16'h0fa0);
		pulse_off();
		rreg(drive_ref_pkg::REG_COMM_REF, v);
		chk(v, 32'h0fa0);
		wreg(drive_ref_pkg::REG_MAIN, 32'h0);
		rreg(drive_ref_pkg::REG_COMM_REF, v);
		chk(v, 32'h0);
	endtask
	task automatic t_lim;
		@(posedge clk) keypad_ref <= 16'h1b58;
		wreg(drive_ref_pkg::REG_UPPER, 32'h1f4);
		settle();
		chk(freq_ref, 16'h0bb8);
		wreg(drive_ref_pkg::REG_FMAX2, 32'h0fa0);
		@(posedge clk) motor_sel <= 1'b1;
		settle();
		chk(freq_ref, 16'h07d0);
		@(posedge clk) motor_sel <= 1'b0;
		@(posedge clk) keypad_ref <= 16'h0064;
		wreg(drive_ref_pkg::REG_LOWER, 32'h64);
		settle();
		chk(freq_ref, 16'h0258);
		@(posedge clk) sleeping <= 1'b1;
		settle();
		chk(pid_limited, 16'h0258);
		wreg(drive_ref_pkg::REG_SLEEP_LIM, 32'h1);
		settle();
		chk(pid_limited, 16'h0000);
		@(posedge clk) sleeping <= 1'b0;
		pid_out <= 16'h1b58;
		settle();
		chk(pid_limited, 16'h0bb8);
		wreg(drive_ref_pkg::REG_LOWER, 32'h258);
		settle();
		chk(errors.limit_range_error, 1'b1);
	endtask
	task automatic t_run;
		wreg(drive_ref_pkg::REG_RUN_SRC, 32'h2);
		@(posedge clk) comm_run <= 2'b10;
		settle();
		chk(run_cmd, 2'b10);
		wreg(drive_ref_pkg::REG_RUN_SRC, 32'h3);
		@(posedge clk) plc_run <= 2'b01;
		settle();
		chk(run_cmd, 2'b01);
		wreg(drive_ref_pkg::REG_RUN_SRC, 32'h0);
		@(posedge clk) keypad_run <= 2'b10;
		settle();
		chk(run_cmd, 2'b10);
	endtask
	task automatic t_hold;
		wreg(drive_ref_pkg::REG_TERM_LO, 32'h1a35);
		settle();
		chk(errors.start_mode_conflict_error, 1'b1);
		wreg(drive_ref_pkg::REG_TERM_LO, 32'h35);
		wreg(drive_ref_pkg::REG_RUN_SRC, 32'h1);
		settle();
		chk(errors.start_mode_conflict_error, 1'b0);
		field.press(8'h11);
		repeat (10) @(posedge clk);
		field.press(8'h00);
		repeat (30) @(posedge clk);
		#1 chk(run_cmd, 2'b00);
		field.press(8'h11);
		for (n = 0; n < 60 && run_cmd.fwd !== 1'b1; n++) begin
			@(posedge clk);
			#1;
		end
		if (n == 60) begin
			fails++;
			finish_test();
		end
		chk(n >= 20, 1'b1);
		field.press(8'h01);
		repeat (8) @(posedge clk);
		#1 chk(run_cmd, 2'b00);
		field.press(8'h12);
		repeat (30) @(posedge clk);
		#1 chk(run_cmd, 2'b01);
	endtask
	task automatic t_lang;
		wreg(drive_ref_pkg::REG_LANG, 32'h2);
		@(posedge clk) settings_init <= 1'b1;
		@(posedge clk) settings_init <= 1'b0;
		settle();
		chk(language, 2'h2);
		chk(analog_type, 3'h1);
		rreg(drive_ref_pkg::REG_UPPER, v);
		chk(v, 32'h3e8);
	endtask
	task automatic t_ext;
		wreg(drive_ref_pkg::REG_AIN_TYPE, 32'h3);
		wreg(drive_ref_pkg::REG_MAIN, 32'h1);
		@(posedge clk) first_analog_input <= 12'hc00;
		settle();
		chk(freq_ref, 16'h0000);
		@(posedge clk) first_analog_input <= 12'h400;
		second_analog_input <= 12'h733;
		wreg(drive_ref_pkg::REG_AIN2_FN, 32'ha);
		settle();
		chk(freq_ref, 16'h130b);
		wreg(drive_ref_pkg::REG_MAIN, 32'h7);
		settle();
		chk(freq_ref, 16'h0000);
		@(posedge clk) pulse_train_input <= 16'h0200;
		wreg(drive_ref_pkg::REG_MAIN, 32'h4);
		wreg(drive_ref_pkg::REG_PULSE_FN, 32'h1);
		settle();
		chk(freq_ref, 16'h0000);
		wreg(drive_ref_pkg::REG_PULSE_FN, 32'h0);
		settle();
		chk(freq_ref, 16'h0200);
		wreg(drive_ref_pkg::REG_TERM_LO, 32'h0706);
		wreg(drive_ref_pkg::REG_MAIN, 32'h2);
		// Up held for 40 synced edges gives exactly ten ticks
		field.press(8'h04);
		repeat (40) @(posedge clk);
		field.press(8'h00);
		settle();
		chk(freq_ref, 16'h000a);
		field.press(8'h08);
		repeat (40) @(posedge clk);
		settle();
		chk(freq_ref, 16'h0000);
	endtask

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		{srst, wr, rd, settings_init, power_off, sleeping, motor_sel} = 7'h40;
		addr = 5'h00;
		wdata = 32'h0;
		{keypad_run, comm_run, plc_run} = 6'h00;
		keypad_ref = 16'h04d2;
		pid_out = 16'h0bb8;
		pulse_train_input = 16'h0309;
		first_analog_input = 12'h800;
		second_analog_input = 12'h400;
		repeat (10) @(posedge clk);
		srst <= 1'b0;
		t_regs();
		t_src();
		t_sum();
		t_comm();
		t_lim();
		t_run();
		t_hold();
		t_lang();
		t_ext();
		finish_test();
	end
endmodule
`default_nettype wire
